// ---- slm_strap_pins.sv ----
// Strap latch and multifunction pins, with an AXI4-Lite register slave.
// Assumes straps and pin inputs are synchronous to clk and that the
// monitor and DPLL status arrive as levels on clk.
// Contract
// RULE_01 - At reset release load input strap code into both input config registers.
// RULE_02 - After release, input strap pins are ignored until next reset.
// RULE_03 - At release take three straps as single-ended output clock frequency code.
// RULE_04 - With ref-fail pin enabled, shared pin follows selected-reference-failed status.
// RULE_05 - With ref-fail pin disabled, that pin is high impedance.
// RULE_06 - With lock pin enabled, shared pin drives 1 locked, 0 unlocked.
// RULE_07 - With lock pin disabled, lock pin is driven low.
// RULE_08 - At release take three straps as differential output clock frequency code.
// RULE_09 - After release each general pin follows its direction and output bits.
// RULE_10 - Status register shows every general pin level whatever its direction.
// RULE_11 - Rate-family strap sets reset default of family bit and both digital selects.
// RULE_12 - Family value 0 means SDH rates, 1 means SONET rates.
// RULE_13 - Interrupt control select bit picks pin function; 0, default, is interrupt mode.
// RULE_14 - Interrupt mode offers selectable polarity and push-pull or open-drain drive.
// RULE_15 - Interrupt mode may instead make the pin a plain general output.
// RULE_16 - Select bit 1 shows live activity-monitor state of selected reference.
// RULE_17 - Open input straps pull down to give the 8kHz input default.
// RULE_18 - Open single-ended straps give the 19.44MHz output default.
// RULE_19 - Low reset returns all state to defaults; held two clocks minimum.
// RULE_20 - Straps are captured once per release and held until software writes.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "slm_cfg.svh"

module slm_strap_pins
  import slm_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic           ce,
  // AXI4-Lite write channels.
  input  wire logic [7:0]     awaddr,
  input  wire logic           awvalid,
  output logic                awready,
  input  wire logic [31:0]    wdata,
  input  wire logic [3:0]     wstrb,
  input  wire logic           wvalid,
  output logic                wready,
  output logic [1:0]          bresp,
  output logic                bvalid,
  input  wire logic           bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]     araddr,
  input  wire logic           arvalid,
  output logic                arready,
  output logic [31:0]         rdata,
  output logic [1:0]          rresp,
  output logic                rvalid,
  input  wire logic           rready,
  // Input-only strap pins.
  input  wire logic [2:0]     input_freq_strap,
  input  wire logic           se_out_freq_strap_bit0,
  // Strap bit one of the single-ended code, then reference-fail status.
  input  wire logic           selected_ref_failed_pin_in,
  output logic                selected_ref_failed_pin_out,
  output logic                selected_ref_failed_pin_oe,
  // Strap bit two of the single-ended code, then lock status.
  input  wire logic           lock_pin_in,
  output logic                lock_pin_out,
  output logic                lock_pin_oe,
  // Differential straps and rate family, then general pins one to four.
  input  wire logic [3:0]     gp_pin_in,
  output logic [3:0]          gp_pin_out,
  output logic [3:0]          gp_pin_oe,
  // Interrupt/loss pin, three-state output.
  output logic                irq_pin_out,
  output logic                irq_pin_oe,
  // Live status from the rest of the device.
  input  wire slm_status_type dev_status
);

  slm_phase_type    phase_ff;
  logic [3:0]       input_a_rate_ff;
  logic [3:0]       input_b_rate_ff;
  logic [2:0]       se_freq_ff;
  logic [2:0]       diff_freq_ff;
  logic             rate_family_ff;
  logic             dig1_family_ff;
  logic             dig2_family_ff;
  logic             lock_pin_en_ff;
  logic             ref_fail_pin_en_ff;
  logic [3:0]       gp_dir_ff;
  logic [3:0]       gp_val_ff;
  logic [3:0]       gp_level_ff;
  slm_irq_ctrl_type irq_ctrl_ff;
  logic             aw_held_ff;
  logic             w_held_ff;
  logic [7:0]       aw_addr_ff;
  logic [7:0]       w_byte_ff;
  logic             w_lane0_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [31:0]      rdata_ff;
  logic [1:0]       rresp_ff;
  logic             wr_fire;
  logic             running;
  logic             irq_level;
  logic [31:0]      nxt_rdata;

  // Decode shared by the read and the write path.
  function automatic logic slm_mapped(input logic [7:0] addr);
    slm_mapped = (addr[1:0] == 2'h0) && (addr <= `SLM_ADDR_IRQ_CTRL);
  endfunction : slm_mapped

  // A register is written only on a whole fired write with lane 0 enabled.
  function automatic logic slm_hit(input logic [7:0] addr);
    slm_hit = wr_fire && w_lane0_ff && (aw_addr_ff == addr);
  endfunction : slm_hit

  assign running = (phase_ff == SLM_PH_RUN);

  // Phase: the first enabled edge after release takes the straps, once.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_ff <= SLM_PH_STRAP; // [RULE_19]
    end else if (ce) begin
      phase_ff <= SLM_PH_RUN; // [RULE_20]
    end
  end

  // Strap-loaded registers; after the capture only software changes them.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      input_a_rate_ff <= 4'h0;
      input_b_rate_ff <= 4'h0;
      se_freq_ff      <= 3'h0;
      diff_freq_ff    <= 3'h0;
      rate_family_ff  <= `SLM_FAMILY_SDH;
      dig1_family_ff  <= `SLM_FAMILY_SDH;
      dig2_family_ff  <= `SLM_FAMILY_SDH;
    end else if (ce && !running) begin
      input_a_rate_ff <= {1'h0, input_freq_strap}; // [RULE_01]
      input_b_rate_ff <= {1'h0, input_freq_strap}; // [RULE_01]
      se_freq_ff      <= {lock_pin_in, selected_ref_failed_pin_in, se_out_freq_strap_bit0}; // [RULE_03]
      diff_freq_ff    <= gp_pin_in[2:0]; // [RULE_08]
      rate_family_ff  <= gp_pin_in[3]; // [RULE_11] [RULE_12]
      dig1_family_ff  <= gp_pin_in[3]; // [RULE_11]
      dig2_family_ff  <= gp_pin_in[3]; // [RULE_11]
    end else if (ce) begin
      // Straps are no longer looked at here. [RULE_02]
      if (slm_hit(`SLM_ADDR_INPUT_A)) input_a_rate_ff <= w_byte_ff[3:0];
      if (slm_hit(`SLM_ADDR_INPUT_B)) input_b_rate_ff <= w_byte_ff[3:0];
      if (slm_hit(`SLM_ADDR_OUT_FREQ)) begin
        se_freq_ff   <= w_byte_ff[`SLM_OUT_FREQ_SE_LSB +: 3];
        diff_freq_ff <= w_byte_ff[`SLM_OUT_FREQ_DIFF_LSB +: 3];
      end
      if (slm_hit(`SLM_ADDR_MCFG_THREE)) rate_family_ff <= w_byte_ff[0];
      if (slm_hit(`SLM_ADDR_MCFG_SIX)) begin
        dig1_family_ff <= w_byte_ff[0];
        dig2_family_ff <= w_byte_ff[1];
      end
    end
  end

  // Pin control registers with plain reset defaults.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lock_pin_en_ff     <= `SLM_RST_BIT;
      ref_fail_pin_en_ff <= `SLM_RST_BIT;
      {gp_val_ff, gp_dir_ff} <= `SLM_RST_GP_CTRL;
      irq_ctrl_ff        <= `SLM_RST_IRQ_CTRL; // [RULE_13]
    end else if (ce) begin
      if (slm_hit(`SLM_ADDR_MCFG_ONE)) lock_pin_en_ff <= w_byte_ff[0];
      if (slm_hit(`SLM_ADDR_MCFG_TEN)) ref_fail_pin_en_ff <= w_byte_ff[0];
      if (slm_hit(`SLM_ADDR_GP_CTRL)) {gp_val_ff, gp_dir_ff} <= w_byte_ff;
      if (slm_hit(`SLM_ADDR_IRQ_CTRL)) irq_ctrl_ff <= w_byte_ff[4:0];
    end
  end

  // General pin levels, sampled every enabled cycle whatever the direction.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gp_level_ff <= 4'h0;
    end else if (ce) begin
      gp_level_ff <= gp_pin_in; // [RULE_10]
    end
  end

  // Shared status pins; nothing drives before the straps are taken.
  always_comb begin
    selected_ref_failed_pin_oe  = running && ref_fail_pin_en_ff; // [RULE_04] [RULE_05]
    selected_ref_failed_pin_out = dev_status.ref_failed; // [RULE_04]
    lock_pin_oe    = running; // [RULE_07]
    lock_pin_out   = lock_pin_en_ff && dev_status.dpll_locked; // [RULE_06] [RULE_07]
  end

  // General pins, one slice per pin.
  for (genvar g = 0; g < 4; g++) begin : g_gp
    assign gp_pin_oe[g]  = running && gp_dir_ff[g]; // [RULE_09]
    assign gp_pin_out[g] = gp_val_ff[g]; // [RULE_09]
  end

  // Interrupt/loss pin. Open drain pulls low only and floats otherwise,
  // so the board pull-up decides the high level.
  always_comb begin
    irq_level = irq_ctrl_ff.active_high ? dev_status.irq_pending
                                        : !dev_status.irq_pending; // [RULE_14]
    if (!running) begin
      irq_pin_out = 1'h0;
      irq_pin_oe  = 1'h0;
    end else if (irq_ctrl_ff.loss_sel) begin
      irq_pin_out = dev_status.ref_activity_lost; // [RULE_16]
      irq_pin_oe  = 1'h1;
    end else if (irq_ctrl_ff.gpo_mode) begin
      irq_pin_out = irq_ctrl_ff.gpo_val; // [RULE_15]
      irq_pin_oe  = 1'h1;
    end else if (irq_ctrl_ff.open_drain) begin
      irq_pin_out = 1'h0; // [RULE_14]
      irq_pin_oe  = !irq_level;
    end else begin
      irq_pin_out = irq_level; // [RULE_14]
      irq_pin_oe  = 1'h1;
    end
  end

  // Write path: address and data are taken in either order, then answered.
  assign awready = ce && !aw_held_ff && !bvalid_ff;
  assign wready  = ce && !w_held_ff && !bvalid_ff;
  assign wr_fire = ce && aw_held_ff && w_held_ff && !bvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_held_ff <= 1'h0;
      w_held_ff  <= 1'h0;
      aw_addr_ff <= 8'h00;
      w_byte_ff  <= 8'h00;
      w_lane0_ff <= 1'h0;
      bvalid_ff  <= 1'h0;
      bresp_ff   <= `SLM_RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'h1;
        aw_addr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_ff  <= 1'h1;
        w_byte_ff  <= wdata[7:0];
        w_lane0_ff <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held_ff <= 1'h0;
        w_held_ff  <= 1'h0;
        bvalid_ff  <= 1'h1;
        bresp_ff   <= slm_mapped(aw_addr_ff) ? `SLM_RESP_OKAY : `SLM_RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'h0;
      end
    end
  end

  // Read data; status words show live block state.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (araddr)
      `SLM_ADDR_INPUT_A:    nxt_rdata[3:0] = input_a_rate_ff;
      `SLM_ADDR_INPUT_B:    nxt_rdata[3:0] = input_b_rate_ff;
      `SLM_ADDR_MCFG_ONE:   nxt_rdata[0] = lock_pin_en_ff;
      `SLM_ADDR_MCFG_THREE: nxt_rdata[0] = rate_family_ff;
      `SLM_ADDR_MCFG_SIX:   nxt_rdata[1:0] = {dig2_family_ff, dig1_family_ff};
      `SLM_ADDR_MCFG_TEN:   nxt_rdata[0] = ref_fail_pin_en_ff;
      `SLM_ADDR_MSTAT_TWO:  nxt_rdata[0] = dev_status.ref_failed;
      `SLM_ADDR_OUT_FREQ:   nxt_rdata[6:0] = {diff_freq_ff, 1'h0, se_freq_ff};
      `SLM_ADDR_GP_CTRL:    nxt_rdata[7:0] = {gp_val_ff, gp_dir_ff};
      `SLM_ADDR_GP_STAT:    nxt_rdata[3:0] = gp_level_ff; // [RULE_10]
      `SLM_ADDR_IRQ_CTRL:   nxt_rdata[4:0] = irq_ctrl_ff;
      default:              nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Read path: one read at a time, answered the cycle after it is taken.
  assign arready = ce && !rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rvalid_ff <= 1'h0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `SLM_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid_ff <= 1'h1;
        rdata_ff  <= nxt_rdata;
        rresp_ff  <= slm_mapped(araddr) ? `SLM_RESP_OKAY : `SLM_RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
        rvalid_ff <= 1'h0;
      end
    end
  end

  // Checks on the straps, the pin functions and the write answer.
  default clocking slm_cb @(posedge clk); endclocking
  default disable iff (!rstn);

  strap_input_load_a: assert property ( // [RULE_01]
    (rstn && ce && !running) |=> (input_a_rate_ff == {1'h0, $past(input_freq_strap)})
                         && (input_b_rate_ff == input_a_rate_ff))
    else $error("Input rate code not loaded from straps.");

  strap_ignored_a: assert property ( // [RULE_02]
    (running && !wr_fire && $changed(input_freq_strap)) |=> $stable(input_a_rate_ff))
    else $error("Input rate code moved after release.");

  strap_se_load_a: assert property ( // [RULE_03]
    (rstn && ce && !running) |=> (se_freq_ff ==
      $past({lock_pin_in, selected_ref_failed_pin_in, se_out_freq_strap_bit0})))
    else $error("Single-ended code not loaded from straps.");

  strap_diff_family_a: assert property ( // [RULE_08]
    (rstn && ce && !running) |=> (diff_freq_ff == $past(gp_pin_in[2:0]))
                         && (rate_family_ff == $past(gp_pin_in[3]))
                         && dig1_family_ff == rate_family_ff && dig2_family_ff == rate_family_ff)
    else $error("Differential or family default wrong.");

  ref_fail_pin_a: assert property ( // [RULE_04]
    running |-> (selected_ref_failed_pin_oe == ref_fail_pin_en_ff)
                && (!selected_ref_failed_pin_oe || selected_ref_failed_pin_out == dev_status.ref_failed))
    else $error("Reference-fail pin wrong.");

  lock_pin_drive_a: assert property ( // [RULE_06]
    running |-> lock_pin_oe && (lock_pin_out == (lock_pin_en_ff && dev_status.dpll_locked)))
    else $error("Lock pin wrong.");

  gp_pin_drive_a: assert property ( // [RULE_09]
    running |-> (gp_pin_oe == gp_dir_ff) && (gp_pin_out == gp_val_ff))
    else $error("General pin drive wrong.");

  gp_status_a: assert property ( // [RULE_10]
    (rstn && ce) |=> (gp_level_ff == $past(gp_pin_in)))
    else $error("General pin status stale.");

  irq_loss_mode_a: assert property ( // [RULE_16]
    (running && irq_ctrl_ff.loss_sel) |-> irq_pin_oe
                                         && (irq_pin_out == dev_status.ref_activity_lost))
    else $error("Loss mode pin wrong.");

  irq_open_drain_a: assert property ( // [RULE_14]
    (running && !irq_ctrl_ff.loss_sel && !irq_ctrl_ff.gpo_mode && irq_ctrl_ff.open_drain)
      |-> !irq_pin_out && (irq_pin_oe == (irq_ctrl_ff.active_high != dev_status.irq_pending)))
    else $error("Open-drain interrupt pin wrong.");

  write_answer_a: assert property (
    wr_fire |=> bvalid_ff [*1] ##0 !aw_held_ff)
    else $error("Write not answered.");

  strap_capture_c: cover property (ce && !running ##1 running);
  gp_output_c:     cover property (running && gp_pin_oe[0] ##1 gp_pin_oe[2]);
  loss_mode_c:     cover property (running && irq_ctrl_ff.loss_sel && irq_pin_out);
  unmapped_c:      cover property (bvalid_ff && bresp_ff == `SLM_RESP_SLVERR);

endmodule : slm_strap_pins
`default_nettype wire

// ---- slm_cfg.svh ----
// Constants of the strap latch and multifunction pin block.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, low address byte decoded.
`ifndef SLM_CFG_SVH
`define SLM_CFG_SVH

// Register byte addresses.
`define SLM_ADDR_INPUT_A    8'h00
`define SLM_ADDR_INPUT_B    8'h04
`define SLM_ADDR_MCFG_ONE   8'h08
`define SLM_ADDR_MCFG_THREE 8'h0C
`define SLM_ADDR_MCFG_SIX   8'h10
`define SLM_ADDR_MCFG_TEN   8'h14
`define SLM_ADDR_MSTAT_TWO  8'h18
`define SLM_ADDR_OUT_FREQ   8'h1C
`define SLM_ADDR_GP_CTRL    8'h20
`define SLM_ADDR_GP_STAT    8'h24
`define SLM_ADDR_IRQ_CTRL   8'h28

// Field positions.
`define SLM_OUT_FREQ_SE_LSB   0
`define SLM_OUT_FREQ_DIFF_LSB 4
`define SLM_GP_VAL_LSB        4

// Reset values of the registers that no strap loads.
`define SLM_RST_BIT      1'h0
`define SLM_RST_GP_CTRL  8'h00
`define SLM_RST_IRQ_CTRL 5'h00

// Rate family encoding.
`define SLM_FAMILY_SDH   1'h0
`define SLM_FAMILY_SONET 1'h1

// Write response codes.
`define SLM_RESP_OKAY   2'h0
`define SLM_RESP_SLVERR 2'h2

`endif

// ---- slm_pkg.sv ----
// Types of the strap latch and multifunction pin block.
// Assumes slm_cfg.svh carries the numeric constants.
package slm_pkg;

  // Live status from the monitors and the DPLL.
  typedef struct packed {
    logic dpll_locked;
    logic ref_failed;
    logic ref_activity_lost;
    logic irq_pending;
  } slm_status_type;

  // Interrupt/loss pin control fields.
  typedef struct packed {
    logic gpo_val;
    logic gpo_mode;
    logic open_drain;
    logic active_high;
    logic loss_sel;
  } slm_irq_ctrl_type;

  // Whether straps are still to be taken or the pins run.
  typedef enum logic {
    SLM_PH_STRAP,
    SLM_PH_RUN
  } slm_phase_type;

endpackage : slm_pkg

// ---- slm_board_model.sv ----
// Board side of the strap and multifunction pins: strap drive, pulls and
// far-end logic. Assumes the bench raises strap_en only around reset.
`timescale 1ns/10ps
`default_nettype none

module slm_board_model (
  // Strap drive, bits {ref-fail, lock, general pins four to one}.
  input  wire logic       strap_en,
  input  wire logic [5:0] strap_val,
  // Far-end logic on the general pins.
  input  wire logic [3:0] ext_en,
  input  wire logic [3:0] ext_val,
  // Device side of the shared pins.
  input  wire logic       selected_ref_failed_pin_out,
  input  wire logic       selected_ref_failed_pin_oe,
  input  wire logic       lock_pin_out,
  input  wire logic       lock_pin_oe,
  input  wire logic [3:0] gp_pin_out,
  input  wire logic [3:0] gp_pin_oe,
  // Resolved wire levels.
  output logic            selected_ref_failed_pin_in,
  output logic            lock_pin_in,
  output logic [3:0]      gp_pin_in
);
  // Internal pulls; an open strap rests here, so open pins give the defaults.
  localparam logic [5:0] PULLS = 6'h24;

  // The device wins, then the straps, then far-end logic, then the pull.
  always_comb begin
    selected_ref_failed_pin_in = selected_ref_failed_pin_oe ? selected_ref_failed_pin_out : (strap_en ? strap_val[5] : PULLS[5]);
    lock_pin_in   = lock_pin_oe ? lock_pin_out : (strap_en ? strap_val[4] : PULLS[4]);
    for (int i = 0; i < 4; i++) begin
      gp_pin_in[i] = gp_pin_oe[i] ? gp_pin_out[i] :
                     strap_en ? strap_val[i] : ext_en[i] ? ext_val[i] : PULLS[i];
    end
  end
endmodule : slm_board_model

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the strap latch and multifunction pins.
// Assumes slm_board_model resolves every shared pin wire.
`timescale 1ns/10ps
`default_nettype none
`include "slm_cfg.svh"

module tb_top
  import slm_pkg::*;
  ;
  logic           clk, rstn, ce, awvalid, wvalid, bready, arvalid, rready, strap_en;
  logic           awready, wready, bvalid, arready, rvalid, se_out_freq_strap_bit0;
  logic           selected_ref_failed_pin_in, selected_ref_failed_pin_out, selected_ref_failed_pin_oe, irq_pin_out, irq_pin_oe;
  logic           lock_pin_in, lock_pin_out, lock_pin_oe;
  logic [7:0]     awaddr, araddr;
  logic [31:0]    wdata, rdata;
  logic [3:0]     wstrb, gp_pin_in, gp_pin_out, gp_pin_oe, ext_en, ext_val;
  logic [1:0]     bresp, rresp;
  logic [2:0]     input_freq_strap;
  logic [5:0]     strap_val;
  slm_status_type dev_status;
  int             err_count, compares;

  // Free-running 200 MHz clock.
  always #2.5 clk = ~clk;

  slm_strap_pins dut_u (
    .clk(clk), .rstn(rstn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .input_freq_strap(input_freq_strap), .se_out_freq_strap_bit0(se_out_freq_strap_bit0),
    .selected_ref_failed_pin_in(selected_ref_failed_pin_in), .selected_ref_failed_pin_out(selected_ref_failed_pin_out),
    .selected_ref_failed_pin_oe(selected_ref_failed_pin_oe), .lock_pin_in(lock_pin_in), .lock_pin_out(lock_pin_out),
    .lock_pin_oe(lock_pin_oe), .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out),
    .gp_pin_oe(gp_pin_oe), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
    .dev_status(dev_status));

  slm_board_model board_u (
    .strap_en(strap_en), .strap_val(strap_val), .ext_en(ext_en), .ext_val(ext_val),
    .selected_ref_failed_pin_out(selected_ref_failed_pin_out), .selected_ref_failed_pin_oe(selected_ref_failed_pin_oe),
    .lock_pin_out(lock_pin_out), .lock_pin_oe(lock_pin_oe), .gp_pin_out(gp_pin_out),
    .gp_pin_oe(gp_pin_oe), .selected_ref_failed_pin_in(selected_ref_failed_pin_in), .lock_pin_in(lock_pin_in),
    .gp_pin_in(gp_pin_in));

  task automatic give_verdict;
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // A bus answer that never comes ends the run rather than hanging it.
  task automatic hang;
    err_count++;
    $display("CHECK FAILED %0t: no bus answer", $time);
    give_verdict();
  endtask : hang

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int   n;
    logic aw_go, w_go, b_go;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    resp = 2'h0;
    for (n = 0; n < 40; n++) begin
      // Handshakes are judged before the edge, where they have settled.
      @(negedge clk);
      aw_go = awvalid && awready;
      w_go  = wvalid && wready;
      b_go  = bvalid;
      resp  = bresp;
      @(posedge clk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      if (b_go) break;
    end
    if (n == 40) hang();
    bready <= 1'b0;
  endtask : axi_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] eresp);
    int          n;
    logic        a_go, r_go;
    logic [31:0] seen;
    logic [1:0]  sr;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    seen = 32'h0000_0000;
    sr   = 2'h0;
    for (n = 0; n < 40; n++) begin
      // Data and handshake are taken before the edge that completes the read.
      @(negedge clk);
      a_go = arvalid && arready;
      r_go = rvalid;
      seen = rdata;
      sr   = rresp;
      @(posedge clk);
      if (a_go) arvalid <= 1'b0;
      if (r_go) break;
    end
    if (n == 40) hang();
    chk(seen, exp);
    chk({30'h0, sr}, {30'h0, eresp});
    rready <= 1'b0;
  endtask : rd_chk

  // Lets the edge's updates land before the pins are looked at.
  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle

  task automatic do_reset(input logic [2:0] ipf, input logic se0, input logic en,
                          input logic [5:0] sv);
    rstn                   <= 1'b0;
    strap_en               <= en;
    strap_val              <= sv;
    ext_en                 <= 4'h0;
    input_freq_strap       <= ipf;
    se_out_freq_strap_bit0 <= se0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    strap_en <= 1'b0;
  endtask : do_reset

  // Driven straps become defaults; later strap changes are ignored.
  task automatic scen_straps;
    logic [1:0] r;
    do_reset(3'h5, 1'b1, 1'b1, 6'h1B);
    rd_chk(`SLM_ADDR_INPUT_A, 32'h5, `SLM_RESP_OKAY);
    rd_chk(`SLM_ADDR_INPUT_B, 32'h5, `SLM_RESP_OKAY);
    rd_chk(`SLM_ADDR_OUT_FREQ, 32'h35, `SLM_RESP_OKAY);
    rd_chk(`SLM_ADDR_MCFG_THREE, {31'h0, `SLM_FAMILY_SONET}, `SLM_RESP_OKAY);
    rd_chk(`SLM_ADDR_MCFG_SIX, 32'h3, `SLM_RESP_OKAY);
    rd_chk(`SLM_ADDR_IRQ_CTRL, 32'h0, `SLM_RESP_OKAY);
    input_freq_strap       <= 3'h2;
    se_out_freq_strap_bit0 <= 1'b0;
    axi_wr(`SLM_ADDR_INPUT_A, 32'h9, r);
    chk({30'h0, r}, {30'h0, `SLM_RESP_OKAY});
    rd_chk(`SLM_ADDR_INPUT_A, 32'h9, `SLM_RESP_OKAY);
    rd_chk(`SLM_ADDR_INPUT_B, 32'h5, `SLM_RESP_OKAY);
    rd_chk(`SLM_ADDR_OUT_FREQ, 32'h35, `SLM_RESP_OKAY);
    rd_chk(8'h2C, 32'h0, `SLM_RESP_SLVERR);
    axi_wr(8'h2C, 32'h1, r);
    chk({30'h0, r}, {30'h0, `SLM_RESP_SLVERR});
  endtask : scen_straps

  // Reference-fail and lock pins, disabled and then enabled.
  task automatic scen_status;
    logic [1:0] r;
    dev_status <= slm_status_type'(4'hC);
    settle();
    chk({selected_ref_failed_pin_oe, lock_pin_oe, lock_pin_out}, 32'h2);
    axi_wr(`SLM_ADDR_MCFG_ONE, 32'h1, r);
    axi_wr(`SLM_ADDR_MCFG_TEN, 32'h1, r);
    for (int i = 0; i < 2; i++) begin
      dev_status <= slm_status_type'({i[0], i[0], 2'h0});
      settle();
      chk({selected_ref_failed_pin_oe, selected_ref_failed_pin_out, lock_pin_oe, lock_pin_out}, {1'b1, i[0], 1'b1, i[0]});
      rd_chk(`SLM_ADDR_MSTAT_TWO, {31'h0, i[0]}, `SLM_RESP_OKAY);
    end
  endtask : scen_status

  // Two pins driven by the device, two by far-end logic.
  task automatic scen_gp;
    logic [1:0] r;
    ext_en  <= 4'hF;
    ext_val <= 4'hA;
    axi_wr(`SLM_ADDR_GP_CTRL, 32'h15, r);
    settle();
    chk({gp_pin_oe, gp_pin_out}, 32'h51);
    rd_chk(`SLM_ADDR_GP_STAT, 32'hB, `SLM_RESP_OKAY);
    // A low clock enable stalls the bus, so nothing may be taken.
    ce <= 1'b0;
    settle();
    chk({awready, wready, arready}, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
  endtask : scen_gp

  // Each entry: control, pending, lost, expected level, expected enable.
  task automatic scen_irq;
    logic [1:0] r;
    logic [8:0] tab [9] = '{9'h009, 9'h003, 9'h02B, 9'h049, 9'h040,
                             9'h089, 9'h183, 9'h017, 9'h019};
    for (int i = 0; i < 9; i++) begin
      axi_wr(`SLM_ADDR_IRQ_CTRL, {27'h0, tab[i][8:4]}, r);
      dev_status <= slm_status_type'({2'h0, tab[i][2], tab[i][3]});
      settle();
      chk({irq_pin_oe, irq_pin_oe & irq_pin_out}, {tab[i][0], tab[i][1]});
    end
  endtask : scen_irq

  // A second reset with every strap open restores all defaults.
  task automatic scen_open;
    do_reset(3'h0, 1'b1, 1'b0, 6'h00);
    rd_chk(`SLM_ADDR_INPUT_B, 32'h0, `SLM_RESP_OKAY);
    rd_chk(`SLM_ADDR_OUT_FREQ, 32'h43, `SLM_RESP_OKAY);
    rd_chk(`SLM_ADDR_MCFG_THREE, {31'h0, `SLM_FAMILY_SDH}, `SLM_RESP_OKAY);
    rd_chk(`SLM_ADDR_GP_CTRL, 32'h0, `SLM_RESP_OKAY);
    rd_chk(`SLM_ADDR_MCFG_TEN, 32'h0, `SLM_RESP_OKAY);
  endtask : scen_open

  // Main sequence; every input gets a value at time zero.
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, strap_en} = '0;
    {awaddr, araddr, wdata, wstrb, ext_en, ext_val, strap_val} = '0;
    input_freq_strap = 3'h0;
    se_out_freq_strap_bit0 = 1'b1;
    dev_status = '0;
    err_count = 0;
    compares = 0;
    @(posedge clk);
    scen_straps();
    scen_status();
    scen_gp();
    scen_irq();
    scen_open();
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
